/* rtl/osc_reset_buck_defs.svh */
// named offsets, field positions, reset values and timing figures
`ifndef OSC_RESET_BUCK_DEFS_SVH
`define OSC_RESET_BUCK_DEFS_SVH
// ==================================================================
// register offsets
`define OFS_OSC_CLOCK_OUTPUT_CONTROL 9'h098
`define OFS_RESET_RELEASE_TIMER      9'h099
`define OFS_CONV3_CURRENT_LIMIT      9'h09A
`define OFS_CONV4_CURRENT_LIMIT      9'h09B
`define OFS_CONV12_CURRENT_LIMIT     9'h09C
`define OFS_CONV2_CONFIG             9'h09D
`define OFS_CONV1_CONFIG             9'h09E
`define OFS_CONV4_CONFIG             9'h09F
`define OFS_CONV3_CONFIG             9'h0A0
`define REG_RESET_VALUE              8'h00
`define RDATA_UNMAPPED               8'h00
// ==================================================================
// oscillator control fields
`define BIT_CLK_OUTPUT_ENABLE 7
`define BIT_RTC_CLOCK_GATE    6
`define BIT_OUT_CLOCK_GATE    5
`define BIT_DELAY_MODE        4
`define BIT_CRYSTAL_PRESENT   3
`define SETTLE_CODE_HI        2
`define SETTLE_CODE_LO        0
// ==================================================================
// reset timer fields
`define RESET_EVENT_HI 7
`define RESET_EVENT_LO 6
`define RESET_TIMER_HI 5
`define RESET_TIMER_LO 0
`define RESET_LINEAR_MAX   6'h1F
`define RESET_LONG_SCALE   11'h020
`define RESET_LONG_BASE    11'h01F
// ==================================================================
// converter fields
`define LIMIT_LO_HI    3
`define LIMIT_LO_LO    0
`define LIMIT_HI_HI    7
`define LIMIT_HI_LO    4
`define OP_SELECT_HI   7
`define OP_SELECT_LO   6
`define BIT_PULLDOWN_OFF      5
`define BIT_TERMINATION_MODE  4
`define BIT_TERMINATION_REF   3
`define LIMIT_BASE_CONV3_MA   13'd1700
`define LIMIT_BASE_MA         13'd700
`define LIMIT_STEP_MA         13'd100
// ==================================================================
// timing: settle times in ms, reset tick 1.024 ms, clock 50 MHz
`define CLK_MHZ              50
`define RESET_TICK_US        1024
`define SETTLE_TICK_US       1000
`define SETTLE_MS_1          12'd520
`define SETTLE_MS_2          12'd1000
`define SETTLE_MS_3          12'd1500
`define SETTLE_MS_4          12'd2100
`define SETTLE_MS_5          12'd2600
`define SETTLE_MS_6          12'd3100
`define SETTLE_MS_7          12'd3600
`define OSC_EDGES_BEFORE_START 2'd2
`define STRAP_SYNC_WAIT        2'd2
`endif

/* rtl/osc_reset_buck_pkg.sv */
// types shared by the oscillator, reset-release and converter control slice
package osc_reset_buck_pkg;
  // ================================================================
  // converter operation
  typedef enum logic [1:0] {
    OP_FOLLOW_SLEEP = 2'h0,
    OP_PULSE_SLEEP  = 2'h1,
    OP_SYNC_SWITCH  = 2'h2,
    OP_AUTOMATIC    = 2'h3
  } op_select_t;

  typedef enum logic [1:0] {
    START_EXTERNAL_WAKE = 2'h0,
    START_SYSTEM_UP     = 2'h1,
    START_POWERUP       = 2'h2,
    START_RESET_EXIT    = 2'h3
  } reset_start_t;

  typedef enum logic [3:0] {
    OSC_OFF    = 4'h1,
    OSC_EDGES  = 4'h2,
    OSC_SETTLE = 4'h4,
    OSC_READY  = 4'h8
  } osc_state_t;

  typedef enum logic [2:0] {
    RST_HOLD     = 3'h1,
    RST_COUNT    = 3'h2,
    RST_RELEASED = 3'h4
  } rst_state_t;

  // ================================================================
  // per-converter control bundle
  typedef struct packed {
    logic [12:0] limit_ma;
    op_select_t  op_mode;
    logic        pulldown_on;
  } conv_ctrl_t;

  // ================================================================
  // per-converter status from the power stage
  typedef struct packed {
    logic enabled;
    logic sleep_setting_a;
    logic sleep_setting_b;
    logic setting_b_active;
  } conv_status_t;
endpackage : osc_reset_buck_pkg

/* rtl/osc_reset_buck_config.sv */
// oscillator, reset-release timer and converter configuration registers
`timescale 1ns/1ps
`include "osc_reset_buck_defs.svh"

module osc_reset_buck_config
  import osc_reset_buck_pkg::*;
#(
  parameter int SETTLE_TICK_CYCLES = `SETTLE_TICK_US * `CLK_MHZ,
  parameter int RESET_TICK_CYCLES  = `RESET_TICK_US * `CLK_MHZ
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [8:0]   reg_addr,
  input  wire logic         reg_write,
  input  wire logic [7:0]   reg_wdata,
  output logic      [7:0]   reg_rdata,
  input  wire logic         osc_signal_in,
  input  wire logic         osc_switched_on,
  input  wire logic         crystal_strap_in,
  input  wire logic         seq_clock_step_reached,
  input  wire logic         clk_output_pause_active,
  input  wire logic         external_wake,
  input  wire logic         system_powerup_request,
  input  wire logic         powerup_request,
  input  wire logic         reset_mode_exit,
  input  wire logic         reset_mode_enter,
  input  wire logic         full_current_mode,
  input  conv_status_t [3:0] conv_status,
  output logic              rtc_counter_clock_enable,
  output logic              slow_clock_output_function,
  output logic              osc_settled,
  output logic              system_reset_out_n,
  output conv_ctrl_t [3:0]  conv_ctrl,
  output logic              termination_mode_enable,
  output logic              termination_reference_enable
);

  // ================================================================
  // register storage, converter index 0..3 is conv1..conv4
  logic [7:0] osc_clock_output_control;
  logic [7:0] reset_release_timer;
  logic [7:0] conv3_current_limit;
  logic [7:0] conv4_current_limit;
  logic [7:0] conv12_current_limit;
  logic [7:0] conv_config [4];

  // reserved bits are kept whole so software reads back what it wrote
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reset_release_timer  <= `REG_RESET_VALUE;
      conv3_current_limit  <= `REG_RESET_VALUE;
      conv4_current_limit  <= `REG_RESET_VALUE;
      conv12_current_limit <= `REG_RESET_VALUE;
      for (int i = 0; i < 4; i++)
        conv_config[i] <= `REG_RESET_VALUE;
    end
    else if (reg_write)
    begin
      unique case (reg_addr)
        `OFS_RESET_RELEASE_TIMER:  reset_release_timer  <= reg_wdata;
        `OFS_CONV3_CURRENT_LIMIT:  conv3_current_limit  <= reg_wdata;
        `OFS_CONV4_CURRENT_LIMIT:  conv4_current_limit  <= reg_wdata;
        `OFS_CONV12_CURRENT_LIMIT: conv12_current_limit <= reg_wdata;
        `OFS_CONV1_CONFIG:         conv_config[0]       <= reg_wdata;
        `OFS_CONV2_CONFIG:         conv_config[1]       <= reg_wdata;
        `OFS_CONV3_CONFIG:         conv_config[2]       <= reg_wdata;
        `OFS_CONV4_CONFIG:         conv_config[3]       <= reg_wdata;
        default:                   ;
      endcase
    end
  end

  // ================================================================
  // crystal strap: synchronised, then loaded once after reset release
  logic       strap_s1;
  logic       strap_s2;
  logic [1:0] strap_wait;
  logic       strap_loaded;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end
    else
    begin
      strap_s1 <= crystal_strap_in;
      strap_s2 <= strap_s1;
    end
  end

  // wait for the synchroniser to fill before trusting the strap
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_wait   <= 2'h0;
      strap_loaded <= 1'b0;
    end
    else if (!strap_loaded)
    begin
      if (strap_wait == `STRAP_SYNC_WAIT)
        strap_loaded <= 1'b1;
      else
        strap_wait <= strap_wait + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      osc_clock_output_control <= `REG_RESET_VALUE;
    else if (!strap_loaded && strap_wait == `STRAP_SYNC_WAIT)
      osc_clock_output_control[`BIT_CRYSTAL_PRESENT] <= strap_s2;
    else if (reg_write && reg_addr == `OFS_OSC_CLOCK_OUTPUT_CONTROL)
      osc_clock_output_control <= reg_wdata;
  end

  // ================================================================
  // register read, one cycle after the address
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= `RDATA_UNMAPPED;
    else
    begin
      unique case (reg_addr)
        `OFS_OSC_CLOCK_OUTPUT_CONTROL: reg_rdata <= osc_clock_output_control;
        `OFS_RESET_RELEASE_TIMER:      reg_rdata <= reset_release_timer;
        `OFS_CONV3_CURRENT_LIMIT:      reg_rdata <= conv3_current_limit;
        `OFS_CONV4_CURRENT_LIMIT:      reg_rdata <= conv4_current_limit;
        `OFS_CONV12_CURRENT_LIMIT:     reg_rdata <= conv12_current_limit;
        `OFS_CONV1_CONFIG:             reg_rdata <= conv_config[0];
        `OFS_CONV2_CONFIG:             reg_rdata <= conv_config[1];
        `OFS_CONV3_CONFIG:             reg_rdata <= conv_config[2];
        `OFS_CONV4_CONFIG:             reg_rdata <= conv_config[3];
        default:                       reg_rdata <= `RDATA_UNMAPPED;
      endcase
    end
  end

  // ================================================================
  // oscillator edge detection, the pin is asynchronous
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic osc_fall;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end
    else
    begin
      osc_s1 <= osc_signal_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  assign osc_fall = osc_s3 & ~osc_s2;

  // ================================================================
  // stabilisation timer
  function automatic logic [11:0] settle_ms(input logic [2:0] code);
    unique case (code)
      3'h1:    settle_ms = `SETTLE_MS_1;
      3'h2:    settle_ms = `SETTLE_MS_2;
      3'h3:    settle_ms = `SETTLE_MS_3;
      3'h4:    settle_ms = `SETTLE_MS_4;
      3'h5:    settle_ms = `SETTLE_MS_5;
      3'h6:    settle_ms = `SETTLE_MS_6;
      3'h7:    settle_ms = `SETTLE_MS_7;
      default: settle_ms = 12'h000;
    endcase
  endfunction : settle_ms

  osc_state_t  osc_state;
  logic [1:0]  osc_edge_cnt;
  logic [31:0] settle_cnt;
  logic [31:0] settle_target;
  logic [2:0]  settle_code;

  assign settle_code   = osc_clock_output_control[`SETTLE_CODE_HI:`SETTLE_CODE_LO];
  // code 000 gives a zero target, so the timer ends at once
  assign settle_target = 32'(settle_ms(settle_code)) * 32'(SETTLE_TICK_CYCLES);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_state    <= OSC_OFF;
      osc_edge_cnt <= 2'h0;
      settle_cnt   <= 32'h0;
    end
    else if (!osc_switched_on)
      osc_state <= OSC_OFF;
    else
    begin
      unique case (osc_state)
        OSC_OFF:
        begin
          osc_edge_cnt <= 2'h0;
          settle_cnt   <= 32'h0;
          if (osc_clock_output_control[`BIT_DELAY_MODE])
            osc_state <= OSC_SETTLE;
          else
            osc_state <= OSC_EDGES;
        end
        OSC_EDGES:
          if (osc_fall)
          begin
            if (osc_edge_cnt == `OSC_EDGES_BEFORE_START)
              osc_state <= OSC_SETTLE;
            else
              osc_edge_cnt <= osc_edge_cnt + 2'h1;
          end
        OSC_SETTLE:
          if (settle_cnt >= settle_target)
            osc_state <= OSC_READY;
          else
            settle_cnt <= settle_cnt + 32'h1;
        OSC_READY:
          ;
      endcase
    end
  end

  // ================================================================
  // clock enables: sequencer step, gating and output bits combined
  // gating only holds the clocks back; it never stops a settled clock
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_settled                <= 1'b0;
      rtc_counter_clock_enable   <= 1'b0;
      slow_clock_output_function <= 1'b0;
    end
    else
    begin
      osc_settled <= (osc_state == OSC_READY);
      rtc_counter_clock_enable <= seq_clock_step_reached && osc_switched_on
        && (!osc_clock_output_control[`BIT_RTC_CLOCK_GATE]
            || osc_state == OSC_READY);
      slow_clock_output_function <= seq_clock_step_reached && osc_switched_on
        && osc_clock_output_control[`BIT_CLK_OUTPUT_ENABLE]
        && !clk_output_pause_active
        && (!osc_clock_output_control[`BIT_OUT_CLOCK_GATE]
            || osc_state == OSC_READY);
    end
  end

  // ================================================================
  // reset-release timer
  reset_start_t rst_event_sel;
  logic [5:0]   rst_code;
  logic         rst_event;
  logic [10:0]  rst_target;
  logic [10:0]  rst_tick_cnt;
  logic [31:0]  rst_prescale;
  rst_state_t   rst_state;

  assign rst_event_sel = reset_start_t'(reset_release_timer[`RESET_EVENT_HI:`RESET_EVENT_LO]);
  assign rst_code      = reset_release_timer[`RESET_TIMER_HI:`RESET_TIMER_LO];

  always_comb
  begin
    unique case (rst_event_sel)
      START_EXTERNAL_WAKE: rst_event = external_wake;
      START_SYSTEM_UP:     rst_event = system_powerup_request;
      START_POWERUP:       rst_event = powerup_request;
      START_RESET_EXIT:    rst_event = reset_mode_exit;
    endcase
  end

  // long codes step by 32 ticks
  assign rst_target = (rst_code <= `RESET_LINEAR_MAX) ? {5'h00, rst_code}
                    : 11'((11'(rst_code) - `RESET_LONG_BASE) * `RESET_LONG_SCALE);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_state    <= RST_HOLD;
      rst_tick_cnt <= 11'h000;
      rst_prescale <= 32'h0;
    end
    else if (reset_mode_enter)
      rst_state <= RST_HOLD;
    else
    begin
      unique case (rst_state)
        RST_HOLD:
        begin
          rst_tick_cnt <= 11'h000;
          rst_prescale <= 32'h0;
          if (rst_event)
          begin
            if (rst_code == 6'h00)
              rst_state <= RST_RELEASED;
            else
              rst_state <= RST_COUNT;
          end
        end
        RST_COUNT:
          if (rst_prescale == 32'(RESET_TICK_CYCLES - 1))
          begin
            rst_prescale <= 32'h0;
            if (rst_tick_cnt + 11'h001 >= rst_target)
              rst_state <= RST_RELEASED;
            else
              rst_tick_cnt <= rst_tick_cnt + 11'h001;
          end
          else
            rst_prescale <= rst_prescale + 32'h1;
        RST_RELEASED:
          ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      system_reset_out_n <= 1'b0;
    else
      system_reset_out_n <= (rst_state == RST_RELEASED);
  end

  // ================================================================
  // converter controls
  logic [3:0] limit_code [4];

  assign limit_code[0] = conv12_current_limit[`LIMIT_LO_HI:`LIMIT_LO_LO];
  assign limit_code[1] = conv12_current_limit[`LIMIT_HI_HI:`LIMIT_HI_LO];
  assign limit_code[2] = conv3_current_limit[`LIMIT_LO_HI:`LIMIT_LO_LO];
  assign limit_code[3] = conv4_current_limit[`LIMIT_LO_HI:`LIMIT_LO_LO];

  for (genvar g = 0; g < 4; g++)
  begin : g_conv
    logic [12:0] base_ma;
    logic [12:0] nominal_ma;
    op_select_t  sel;
    logic        active_sleep;

    assign base_ma    = (g == 2) ? `LIMIT_BASE_CONV3_MA : `LIMIT_BASE_MA;
    assign nominal_ma = base_ma + 13'(limit_code[g] * `LIMIT_STEP_MA);
    assign sel        = op_select_t'(conv_config[g][`OP_SELECT_HI:`OP_SELECT_LO]);
    assign active_sleep = conv_status[g].setting_b_active ? conv_status[g].sleep_setting_b
                                                          : conv_status[g].sleep_setting_a;

    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        conv_ctrl[g] <= '{limit_ma: 13'h0000, op_mode: OP_SYNC_SWITCH, pulldown_on: 1'b0};
      else
      begin
        // full-current doubling only applies to the dual-phase pair
        if (g < 2 && full_current_mode)
          conv_ctrl[g].limit_ma <= 13'(nominal_ma << 1);
        else
          conv_ctrl[g].limit_ma <= nominal_ma;
        if (sel == OP_FOLLOW_SLEEP)
          conv_ctrl[g].op_mode <= active_sleep ? OP_PULSE_SLEEP
                                               : OP_SYNC_SWITCH;
        else
          conv_ctrl[g].op_mode <= sel;
        conv_ctrl[g].pulldown_on <= !conv_status[g].enabled
                                    && !conv_config[g][`BIT_PULLDOWN_OFF];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      termination_mode_enable      <= 1'b0;
      termination_reference_enable <= 1'b0;
    end
    else
    begin
      termination_mode_enable      <= conv_config[3][`BIT_TERMINATION_MODE];
      termination_reference_enable <= conv_config[3][`BIT_TERMINATION_REF];
    end
  end

endmodule : osc_reset_buck_config

/* bench/osc_reset_buck_monitor.sv */
// checker for the oscillator, reset timer and converter register slice
`timescale 1ns/1ps
module osc_reset_buck_monitor
  import osc_reset_buck_pkg::*;
(
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic [8:0]   reg_addr,
  input wire logic         reg_write,
  input wire logic [7:0]   reg_wdata,
  input wire logic [7:0]   reg_rdata,
  input wire logic         osc_switched_on,
  input wire logic         seq_clock_step_reached,
  input wire logic         clk_output_pause_active,
  input wire logic         full_current_mode,
  input wire logic         reset_mode_enter,
  input conv_status_t [3:0] conv_status,
  input wire logic         rtc_counter_clock_enable,
  input wire logic         slow_clock_output_function,
  input wire logic         osc_settled,
  input wire logic         system_reset_out_n,
  input conv_ctrl_t [3:0]  conv_ctrl,
  input wire logic         termination_mode_enable,
  input wire logic         termination_reference_enable
);
  // ========
  // helpers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  function automatic logic [1:0] exp_op(input logic [1:0] m, input conv_status_t s);
    return (m != 2'h0) ? m : ((s.setting_b_active ? s.sleep_setting_b : s.sleep_setting_a)
                              ? 2'h1 : 2'h2);
  endfunction : exp_op

  sequence wr_to(a);
    reg_write && reg_addr == a;
  endsequence
  sequence mapped_write;
    reg_write && reg_addr inside {[9'h098:9'h0A0]};
  endsequence
  sequence held_read;
    !reg_write && $stable(reg_addr);
  endsequence

  // ========
  // register port
  chk_write_readback: assert property (mapped_write ##1 held_read
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback differs from write");
  chk_unmapped_zero: assert property (!(reg_addr inside {[9'h098:9'h0A0]})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");

  // ========
  // converter controls
  chk_conv3_limit: assert property (wr_to(9'h09A) |-> ##2
    conv_ctrl[2].limit_ma == 13'd1700 + 13'd100 * $past(reg_wdata[3:0], 2))
    else $error("conv3 limit wrong");
  chk_conv4_limit: assert property (wr_to(9'h09B) |-> ##2
    conv_ctrl[3].limit_ma == 13'd700 + 13'd100 * $past(reg_wdata[3:0], 2))
    else $error("conv4 limit wrong");
  chk_conv12_limit: assert property ((wr_to(9'h09C) ##0 !full_current_mode [*3]) |->
    conv_ctrl[0].limit_ma == 13'd700 + 13'd100 * $past(reg_wdata[3:0], 2) &&
    conv_ctrl[1].limit_ma == 13'd700 + 13'd100 * $past(reg_wdata[7:4], 2))
    else $error("conv1 or conv2 limit wrong");
  chk_op_follow: assert property (wr_to(9'h09E) |-> ##2
    conv_ctrl[0].op_mode == exp_op($past(reg_wdata[7:6], 2), conv_status[0]))
    else $error("conv1 operation wrong");
  chk_pulldown_off: assert property (wr_to(9'h09E) |-> ##2
    conv_ctrl[0].pulldown_on == (!conv_status[0].enabled && !$past(reg_wdata[5], 2)))
    else $error("conv1 pull-down wrong");
  chk_term_bits: assert property (wr_to(9'h09F) |-> ##2
    {termination_mode_enable, termination_reference_enable} == $past(reg_wdata[4:3], 2))
    else $error("termination enables wrong");

  // ========
  // reset output and clocks
  chk_reset_reenter: assert property (reset_mode_enter |-> ##[1:2] !system_reset_out_n)
    else $error("reset output not reasserted");
  chk_osc_off: assert property (!osc_switched_on [*3] |-> !osc_settled)
    else $error("settled while oscillator off");
  chk_clock_gating: assert property ($past(!osc_switched_on || !seq_clock_step_reached)
    |-> !rtc_counter_clock_enable && !slow_clock_output_function)
    else $error("clock enabled early");
  chk_pause_hold: assert property (slow_clock_output_function
    |-> !$past(clk_output_pause_active)) else $error("slow clock during pause");
endmodule : osc_reset_buck_monitor

bind osc_reset_buck_config osc_reset_buck_monitor mon_u (.*);

/* bench/osc_host_model.sv */
// host side of the register port
`timescale 1ns/1ps
module osc_host_model (
  input  wire logic       clk,
  output logic      [8:0] reg_addr,
  output logic            reg_write,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // ========
  // bus cycles, launched 2 ns after a rising edge
  initial
  begin
    reg_addr  = 9'h000;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end

  // auto mode and late gating only when a test asks for it
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk) #2;
    reg_addr  = a;
    reg_write = 1'b1;
    reg_wdata = d;
    @(posedge clk) #2;
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask : wr

  // read data lags the address by one edge
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk) #2;
    reg_addr = a;
    @(posedge clk) #2;
    d = reg_rdata;
  endtask : rd
endmodule : osc_host_model

/* bench/osc_reset_buck_config_test.sv */
// self-checking bench for the oscillator, reset timer and converter registers
`timescale 1ns/1ps
module osc_reset_buck_config_test;
  import osc_reset_buck_pkg::*;
  localparam int ST = 2;
  localparam int RT = 3;
  logic               clk, reset_n, osc_signal_in, osc_switched_on, crystal_strap_in;
  logic               seq_clock_step_reached, clk_output_pause_active, full_current_mode;
  logic               external_wake, system_powerup_request, powerup_request;
  logic               reset_mode_exit, reset_mode_enter, rtc_counter_clock_enable;
  logic               slow_clock_output_function, osc_settled, system_reset_out_n;
  logic               termination_mode_enable, termination_reference_enable, reg_write;
  logic [8:0]         reg_addr;
  logic [7:0]         reg_wdata, reg_rdata;
  conv_status_t [3:0] conv_status;
  conv_ctrl_t [3:0]   conv_ctrl;
  int                 bad_count, samples_checked;
  logic [16:0]        exp_q[$];
  logic [15:0]        obs_q[$];
  event               obs_ev;

  always #10 clk = ~clk;
  // oscillator stand-in, 14 clocks a period, unrelated to the bus
  always #140 osc_signal_in = ~osc_signal_in;

  osc_reset_buck_config #(.SETTLE_TICK_CYCLES(ST), .RESET_TICK_CYCLES(RT)) dut_u (.*);
  osc_host_model hm (.*);

  // ========
  // checking
  task automatic cmp_reg(input logic [7:0] e, input logic [7:0] o);
    samples_checked++;
    if (o !== e)
    begin
      bad_count++;
      $display("BAD %0t register read %h expected %h", $time, o, e);
    end
  endtask : cmp_reg

  task automatic cmp_port(input logic [15:0] e, input logic [15:0] o);
    samples_checked++;
    if (o !== e)
    begin
      bad_count++;
      $display("BAD %0t port value %h expected %h", $time, o, e);
    end
  endtask : cmp_port

  // batch drain: notes of one step share a wake-up
  always @(obs_ev)
  begin
    logic [16:0] e;
    while (obs_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e[16])
        cmp_reg(e[7:0], obs_q.pop_front());
      else
        cmp_port(e[15:0], obs_q.pop_front());
    end
  end

  task automatic note(input logic k, input logic [15:0] e, input logic [15:0] o);
    exp_q.push_back({k, e});
    obs_q.push_back(o);
    -> obs_ev;
  endtask : note

  task automatic test_done;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic give_up;
    bad_count++;
    $display("BAD %0t wait ran out", $time);
    test_done();
  endtask : give_up

  // ========
  // stimulus helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : cyc

  task automatic rchk(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] d;
    hm.rd(a, d);
    note(1'b1, {8'h00, e}, {8'h00, d});
  endtask : rchk

  task automatic nclk(input logic [1:0] e);
    note(1'b0, 16'(e), {14'h0, rtc_counter_clock_enable, slow_clock_output_function});
  endtask : nclk

  task automatic ok(input logic c);
    note(1'b0, 16'h0001, 16'(c));
  endtask : ok

  task automatic fire(input int k);
    {reset_mode_exit, powerup_request, system_powerup_request, external_wake} = 4'(1 << k);
    cyc(1);
    {reset_mode_exit, powerup_request, system_powerup_request, external_wake} = 4'h0;
  endtask : fire

  task automatic hold_reset;
    reset_mode_enter = 1'b1;
    cyc(1);
    reset_mode_enter = 1'b0;
  endtask : hold_reset

  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1)
    begin
      cyc(1);
      n++;
      if (n > lim)
        give_up();
    end
  endtask : wait_hi

  // ========
  // main sequence
  initial
  begin
    logic [7:0]   d;
    logic [1:0]   m;
    conv_status_t st;
    int           n;
    int           t;
    {clk, reset_n, osc_signal_in, osc_switched_on, clk_output_pause_active} = 5'h00;
    {external_wake, system_powerup_request, powerup_request, reset_mode_exit} = 4'h0;
    {reset_mode_enter, full_current_mode, crystal_strap_in, seq_clock_step_reached} = 4'h3;
    conv_status = '0;
    d = 8'($urandom(32'hDF70));
    repeat (6) @(posedge clk);
    #2 reset_n = 1'b1;
    cyc(8);
    for (int i = 0; i < 10; i++)
      rchk(9'(9'h098 + i), (i == 0) ? 8'h08 : 8'h00);
    for (int i = 0; i < 9; i++)
    begin
      d = 8'($urandom);
      hm.wr(9'(9'h098 + i), d);
      rchk(9'(9'h098 + i), d);
    end
    hm.wr(9'h0A1, 8'hFF);
    rchk(9'h0A1, 8'h00);
    rchk(9'h0A0, d);
    $display("test registers done");
    for (int i = 0; i < 16; i++)
    begin
      hm.wr(9'h09A, 8'(i));
      full_current_mode = i[0];
      hm.wr(9'h09B, 8'(15 - i));
      hm.wr(9'h09C, 8'(i * 17));
      cyc(3);
      note(1'b0, 16'(1700 + 100 * i), 16'(conv_ctrl[2].limit_ma));
      note(1'b0, 16'(700 + 100 * (15 - i)), 16'(conv_ctrl[3].limit_ma));
      note(1'b0, 16'((700 + 100 * i) << i[0]), 16'(conv_ctrl[1].limit_ma));
    end
    $display("test limits done");
    for (int i = 0; i < 16; i++)
    begin
      st = conv_status_t'($urandom);
      hm.wr(9'h09E, 8'(i << 4));
      conv_status[0] = st;
      hm.wr(9'h09F, 8'(i << 3));
      cyc(3);
      m = (st.setting_b_active ? st.sleep_setting_b : st.sleep_setting_a) ? 2'h1 : 2'h2;
      m = (i[3:2] != 2'h0) ? 2'(i[3:2]) : m;
      note(1'b0, 16'(m), 16'(conv_ctrl[0].op_mode));
      note(1'b0, 16'(!st.enabled && !i[1]), 16'(conv_ctrl[0].pulldown_on));
      note(1'b0, 16'(i & 3),
           16'({termination_mode_enable, termination_reference_enable}));
    end
    $display("test converter modes done");
    for (int ev = 0; ev < 4; ev++)
    begin
      hm.wr(9'h099, 8'(ev << 6));
      hold_reset();
      fire((ev + 1) % 4);
      cyc(4);
      ok(!system_reset_out_n);
      fire(ev);
      cyc(2);
      ok(system_reset_out_n);
    end
    for (int k = 0; k < 2; k++)
    begin
      d = k ? 8'h21 : 8'h02;
      t = RT * (k ? 32 * (33 - 31) : 2);
      hm.wr(9'h099, d);
      hold_reset();
      fire(0);
      wait_hi(system_reset_out_n, 400, n);
      ok(n >= t && n <= t + 4);
    end
    $display("test reset release done");
    // gating and delay chosen before switch-on
    hm.wr(9'h098, 8'hF1);
    osc_switched_on = 1'b1;
    cyc(500);
    nclk(2'h0);
    wait_hi(osc_settled, 1000, n);
    n = n + 500;
    ok(n >= 520 * ST - 2 && n <= 520 * ST + 8);
    cyc(3);
    nclk(2'h3);
    clk_output_pause_active = 1'b1;
    cyc(3);
    nclk(2'h2);
    seq_clock_step_reached = 1'b0;
    cyc(3);
    nclk(2'h0);
    osc_switched_on = 1'b0;
    hm.wr(9'h098, 8'hE0);
    osc_switched_on = 1'b1;
    wait_hi(osc_settled, 80, n);
    ok(n >= 26 && n <= 50);
    osc_switched_on = 1'b0;
    hm.wr(9'h098, 8'hF0);
    osc_switched_on = 1'b1;
    wait_hi(osc_settled, 20, n);
    ok(n <= 5);
    $display("test oscillator done");
    cyc(2);
    test_done();
  end
endmodule : osc_reset_buck_config_test
